// File: dv/svsc_host_model.sv
`timescale 1ns/100ps
module svsc_host_model (
    input  wire logic clk_i,
    input  wire logic chain_i,
    input  wire logic chain_oe_i,
    output logic      shift_clk_o,
    output logic      select_n_o,
    output logic      data_o
);
    initial begin
        shift_clk_o = 1'b0;
        select_n_o  = 1'b1;
        data_o      = 1'b0;
    end
    // clock idles low; chain bit taken just before each rise
    task automatic send(input logic [15:0] w, output logic [15:0] seen);
        @(posedge clk_i);
        #2 select_n_o = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            data_o = w[i];
            repeat (4) @(posedge clk_i);
            #2 seen[i] = chain_oe_i ? chain_i : 1'bx;
            shift_clk_o = 1'b1;
            repeat (4) @(posedge clk_i);
            #2 shift_clk_o = 1'b0;
        end
        repeat (4) @(posedge clk_i);
        #2 select_n_o = 1'b1;
        data_o = ~w[0];
        repeat (8) @(posedge clk_i);
        #2;
    endtask : send
endmodule : svsc_host_model

// File: dv/svsc_monitor.sv
`timescale 1ns/100ps
module svsc_monitor
    import svsc_pkg::*;
#(
    parameter int unsigned CAL_CNT     = 20,
    parameter int unsigned TIMEOUT_CNT = 40
) (
    // clock and reset
    input wire logic        core_clk_i,
    input wire logic        resetn_i,
    // pins
    input wire logic        select_n_i,
    input wire logic        mute_n_i,
    input wire logic        zero_cross_gate_enable_i,
    input wire logic        left_zero_cross_i,
    // outputs
    input wire logic        serial_chain_out_oe_o,
    input wire logic [7:0]  left_level_o,
    input wire logic [7:0]  right_level_o,
    input wire logic        left_soft_mute_o,
    input wire logic        left_analog_output_gnd_o,
    input wire logic        calibrating_o,
    input wire logic [15:0] gain_word_o
);
    // sync lag plus slack; only sane for short bench timeouts
    localparam int WIN = TIMEOUT_CNT + 16;
    default clocking dck @(posedge core_clk_i);
    endclocking
    default disable iff (!resetn_i);

    AST_OE_IDLE: assert property (select_n_i[*4] |-> !serial_chain_out_oe_o)
        else $error("chain output driven while deselected");
    AST_LOAD: assert property ($changed(gain_word_o) && mute_n_i && !zero_cross_gate_enable_i |->
        $past(select_n_i, 4) && !$past(select_n_i, 5)) else $error("gain changed without select rise");
    AST_CHAN_MAP: assert property ($stable(gain_word_o)[*2] |->
        {right_level_o, left_level_o} == gain_word_o) else $error("channel level mapping");
    AST_SOFT_MUTE: assert property (left_soft_mute_o == (left_level_o == SOFT_MUTE_CODE))
        else $error("soft mute flag wrong");
    AST_ZC_HOLD: assert property ($rose(select_n_i) && zero_cross_gate_enable_i && !left_zero_cross_i |->
        ##1 ($stable(gain_word_o) || !zero_cross_gate_enable_i || left_zero_cross_i)[*8])
        else $error("level applied without crossing");
    AST_GND_WAIT: assert property ($fell(mute_n_i) && !left_zero_cross_i ##1
        (!mute_n_i && !left_zero_cross_i)[*8] |-> !left_analog_output_gnd_o) else $error("mute did not wait");
    AST_CAL_START: assert property ($fell(mute_n_i) |-> ##[1:WIN] (calibrating_o || mute_n_i))
        else $error("calibration not started");
    AST_CAL_MIN: assert property ($rose(calibrating_o) |-> calibrating_o[*8])
        else $error("calibration too short");
endmodule : svsc_monitor

// File: dv/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    import svsc_pkg::*;
    logic        clk, rst_n, sclk, sel_n, sdi, sdo, oe, mute_n, gate, lzc, rzc, lsm, rsm, lg, rg, cal;
    logic [7:0]  lvl_l, lvl_r;
    logic [15:0] gain, seen;
    int          n_fail, checks_done, cyc;

    svsc_top #(.CAL_CNT(20), .TIMEOUT_CNT(40)) svsc_top_i (.core_clk_i(clk), .resetn_i(rst_n),
        .shift_clk_i(sclk), .select_n_i(sel_n), .serial_word_in_i(sdi), .serial_chain_out_o(sdo),
        .serial_chain_out_oe_o(oe), .mute_n_i(mute_n), .zero_cross_gate_enable_i(gate),
        .left_zero_cross_i(lzc), .right_zero_cross_i(rzc), .left_level_o(lvl_l), .right_level_o(lvl_r),
        .left_soft_mute_o(lsm), .right_soft_mute_o(rsm), .left_analog_output_gnd_o(lg),
        .right_analog_output_gnd_o(rg), .calibrating_o(cal), .gain_word_o(gain));
    svsc_host_model svsc_host_model_i (.clk_i(clk), .chain_i(sdo), .chain_oe_i(oe),
        .shift_clk_o(sclk), .select_n_o(sel_n), .data_o(sdi));

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : wait_cyc
    task automatic wrap_up;
        if (n_fail == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : wrap_up

    task automatic t_word;
        svsc_host_model_i.send(16'ha55a, seen);
        chk("oe", 16'h0000, oe);
        chk("gain", 16'ha55a, gain);
        chk("levels", 16'ha55a, {lvl_r, lvl_l});
        svsc_host_model_i.send(16'h0000, seen);
        chk("chain", 16'ha55a, seen);
        chk("soft", 16'h0003, {lsm, rsm});
        svsc_host_model_i.send(16'h1234, seen);
        chk("chain0", 16'h0000, seen);
    endtask : t_word
    task automatic t_zc;
        gate = 1'b1;
        svsc_host_model_i.send(16'hbeef, seen);
        chk("zc hold", 16'h1234, gain);
        {lzc, rzc} = 2'b11;
        wait_cyc(6);
        chk("zc apply", 16'hbeef, gain);
        {lzc, rzc} = 2'b00;
        svsc_host_model_i.send(16'h0f0f, seen);
        wait_cyc(40);
        chk("zc timeout", 16'h0f0f, gain);
        gate = 1'b0;
        svsc_host_model_i.send(16'h0101, seen);
        chk("no gate", 16'h0101, gain);
    endtask : t_zc
    task automatic t_mute;
        mute_n = 1'b0;
        wait_cyc(10);
        chk("gnd wait", 16'h0000, lg);
        wait_cyc(40);
        chk("gnd", 16'h0003, {lg, rg});
        chk("cal", 16'h0001, cal);
        chk("cleared", GAIN_RESET, gain);
        wait_cyc(30); // held past calibration time
        mute_n = 1'b1;
        wait_cyc(10);
        chk("unmute", 16'h0000, {lg, rg, cal});
        {lzc, rzc} = 2'b11;
        mute_n = 1'b0;
        wait_cyc(8);
        chk("gnd zc", 16'h0001, lg);
        wait_cyc(30);
        mute_n = 1'b1;
    endtask : t_mute

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            n_fail++;
            wrap_up();
        end
    end
    initial begin
        {rst_n, mute_n, gate, lzc, rzc} = 5'b01000;
        n_fail = 0;
        checks_done = 0;
        repeat (16) @(posedge clk);
        #2 rst_n = 1'b1;
        wait_cyc(8);
        t_word();
        t_zc();
        t_mute();
        wrap_up();
    end
endmodule : tb_top

bind svsc_top svsc_monitor #(.CAL_CNT(CAL_CNT), .TIMEOUT_CNT(TIMEOUT_CNT)) svsc_monitor_i (
    .core_clk_i               (core_clk_i),
    .resetn_i                 (resetn_i),
    .select_n_i               (select_n_i),
    .mute_n_i                 (mute_n_i),
    .zero_cross_gate_enable_i (zero_cross_gate_enable_i),
    .left_zero_cross_i        (left_zero_cross_i),
    .serial_chain_out_oe_o    (serial_chain_out_oe_o),
    .left_level_o             (left_level_o),
    .right_level_o            (right_level_o),
    .left_soft_mute_o         (left_soft_mute_o),
    .left_analog_output_gnd_o (left_analog_output_gnd_o),
    .calibrating_o            (calibrating_o),
    .gain_word_o              (gain_word_o)
);

// File: hw/svsc_pkg.sv
package svsc_pkg;
    // serial word
    localparam int unsigned WORD_BITS      = 16;
    localparam int unsigned CHAN_BITS      = 8;
    localparam int unsigned RIGHT_LSB      = 8;   // first byte shifted in lands high
    localparam int unsigned LEFT_LSB       = 0;
    localparam logic [15:0] GAIN_RESET     = 16'h0000;
    localparam logic [7:0]  SOFT_MUTE_CODE = 8'h00;
    localparam int unsigned BIT_CNT_W      = 5;
    localparam logic [4:0]  BIT_CNT_FULL   = 5'h10;

    // timing
    localparam int unsigned CLK_PERIOD_NS  = 40;
    localparam int unsigned CAL_TIME_US    = 2000;
    localparam int unsigned ZC_TIMEOUT_US  = 18000;
    localparam int unsigned CAL_CYCLES     = (CAL_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned ZC_TIMEOUT_CYC = (ZC_TIMEOUT_US * 1000) / CLK_PERIOD_NS;
    localparam int unsigned TMR_W          = 20;

    typedef enum logic [2:0] {
        SVSC_IDLE = 3'b001,
        SVSC_WAIT = 3'b010,
        SVSC_CAL  = 3'b100
    } svsc_state_t;
endpackage : svsc_pkg

// File: hw/svsc_sync.sv
`timescale 1ns/100ps
module svsc_sync #(
    parameter logic RST_VAL = 1'b0
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic resetn_i,
    // async level in, synchronised level out
    input  wire logic async_i,
    output logic      sync_o
);
    logic meta_q;
    logic sync_q;
    logic meta_d;
    logic sync_d;

    always_comb begin
        meta_d = async_i;
        sync_d = meta_q;
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_o = sync_q;
endmodule : svsc_sync

// File: hw/svsc_top.sv
// Notes on behaviour
// - serial output tri-stated while deselected
// - select falling starts new 16-bit word
// - select rising after 16 bits loads shift register into gain
// - hardware mute grounds both outputs
// - mute falling edge starts offset calibration
// - zero-cross mode applies levels at crossing/timeout
// - zero-cross enable high gates, low bypasses
// - bits captured on rising clock, right first
// - chain output shifts on falling clock edge
// - all-zero code is software mute
// - hardware mute waits crossing or 18 ms
`timescale 1ns/100ps
module svsc_top
    import svsc_pkg::*;
#(
    parameter int unsigned CAL_CNT     = CAL_CYCLES,
    parameter int unsigned TIMEOUT_CNT = ZC_TIMEOUT_CYC
) (
    // clock and reset
    input  wire logic       core_clk_i,
    input  wire logic       resetn_i,
    // serial link pins
    input  wire logic       shift_clk_i,
    input  wire logic       select_n_i,
    input  wire logic       serial_word_in_i,
    output logic            serial_chain_out_o,
    output logic            serial_chain_out_oe_o,
    // control pins
    input  wire logic       mute_n_i,
    input  wire logic       zero_cross_gate_enable_i,
    // per-channel zero crossing flags from the analog side
    input  wire logic       left_zero_cross_i,
    input  wire logic       right_zero_cross_i,
    // analog path control
    output logic [7:0]      left_level_o,
    output logic [7:0]      right_level_o,
    output logic            left_soft_mute_o,
    output logic            right_soft_mute_o,
    output logic            left_analog_output_gnd_o,
    output logic            right_analog_output_gnd_o,
    output logic            calibrating_o,
    output logic [15:0]     gain_word_o
);
    // every pin enters through two flops
    localparam int unsigned NPIN = 7;
    // flops reset to each pin's idle level, so no false edge follows reset
    localparam logic [NPIN-1:0] PIN_IDLE = 7'h0a;
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_s;
    assign pin_raw = {right_zero_cross_i, left_zero_cross_i, zero_cross_gate_enable_i,
                      mute_n_i, serial_word_in_i, select_n_i, shift_clk_i};

    genvar g;
    generate
        for (g = 0; g < NPIN; g++) begin : g_sync
            svsc_sync #(.RST_VAL(PIN_IDLE[g])) u_sync (
                .clk_i    (core_clk_i),
                .resetn_i (resetn_i),
                .async_i  (pin_raw[g]),
                .sync_o   (pin_s[g])
            );
        end
    endgenerate

    logic sclk_s, sel_n_s, sdi_s, mute_n_s, zero_cross_gate_enable_s, zc_l_s, zc_r_s;
    assign {zc_r_s, zc_l_s, zero_cross_gate_enable_s, mute_n_s, sdi_s, sel_n_s, sclk_s} = pin_s;

    // serial state
    logic                 sclk_q, sclk_d;
    logic                 sel_n_q, sel_n_d;
    logic                 mute_n_q, mute_n_d;
    logic [15:0]          shift_q, shift_d;
    logic [15:0]          gain_q, gain_d;
    logic [15:0]          target_q, target_d;
    logic                 sdo_q, sdo_d;
    logic [BIT_CNT_W-1:0] nbits_q, nbits_d;

    logic sclk_rise, sclk_fall, sel_fall, sel_rise, mute_fall;
    assign sclk_rise = sclk_s & ~sclk_q;
    assign sclk_fall = ~sclk_s & sclk_q;
    assign sel_fall  = sel_n_q & ~sel_n_s;
    assign sel_rise  = ~sel_n_q & sel_n_s;
    assign mute_fall = mute_n_q & ~mute_n_s;

    // level apply / mute sequencing
    svsc_state_t      st_q, st_d;
    logic [TMR_W-1:0] tmr_q, tmr_d;
    logic             hw_mute_q, hw_mute_d;
    logic             pend_q, pend_d;
    logic             zc_any;
    assign zc_any = zc_l_s & zc_r_s;
    // latest committed word replaces one still waiting
    logic             apply_now;
    assign apply_now = pend_q && (!zero_cross_gate_enable_s || zc_any || tmr_q == TMR_W'(TIMEOUT_CNT));

    always_comb begin
        sclk_d   = sclk_s;
        sel_n_d  = sel_n_s;
        mute_n_d = mute_n_s;
        shift_d  = shift_q;
        nbits_d  = nbits_q;
        sdo_d    = sdo_q;
        target_d = target_q;
        pend_d   = pend_q;
        if (sel_fall) begin
            nbits_d = '0;
        end
        if (!sel_n_s && sclk_rise) begin
            shift_d = {shift_q[14:0], sdi_s};
            if (nbits_q != BIT_CNT_FULL) begin
                nbits_d = nbits_q + 5'h01;
            end
        end
        if (!sel_n_s && sclk_fall) begin
            sdo_d = shift_q[WORD_BITS-1];
        end
        if (apply_now) begin
            pend_d = 1'b0;
        end
        // short frames are dropped rather than loading a partial word
        if (sel_rise && nbits_q == BIT_CNT_FULL) begin
            target_d = shift_q;
            pend_d   = 1'b1;
        end
        if (!mute_n_s) begin
            // power-up style sequence clears both registers
            shift_d  = GAIN_RESET;
            target_d = GAIN_RESET;
            nbits_d  = '0;
            sdo_d    = 1'b0;
            pend_d   = 1'b0;
        end
    end

    // gain apply: immediate, or gated by zero crossing / timeout
    always_comb begin
        st_d      = st_q;
        tmr_d     = tmr_q;
        hw_mute_d = hw_mute_q;
        gain_d    = gain_q;
        // frames during a mute are ignored, so they must not stretch its timer
        if (sel_rise && st_q == SVSC_IDLE) begin
            tmr_d = '0;
        end else if (tmr_q != TMR_W'(TIMEOUT_CNT)) begin
            tmr_d = tmr_q + 20'h00001;
        end
        if (apply_now) begin
            gain_d = target_q;
        end
        case (st_q)
            SVSC_IDLE: begin
                if (mute_fall) begin
                    st_d  = SVSC_WAIT;
                    tmr_d = '0;
                end
            end
            SVSC_WAIT: begin
                // mute ignores the enable pin
                if (zc_any || tmr_q == TMR_W'(TIMEOUT_CNT)) begin
                    hw_mute_d = 1'b1;
                    st_d      = SVSC_CAL;
                    tmr_d     = '0;
                end
            end
            SVSC_CAL: begin
                // calibration runs for its minimum time
                if (tmr_q >= TMR_W'(CAL_CNT) && mute_n_s) begin
                    hw_mute_d = 1'b0;
                    st_d      = SVSC_IDLE;
                end
            end
            default: st_d = SVSC_IDLE;
        endcase
        if (!mute_n_s && st_q == SVSC_IDLE && !mute_fall) begin
            hw_mute_d = 1'b1;
        end
        if (!mute_n_s) begin
            gain_d = GAIN_RESET;
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sclk_q    <= 1'b0;
            sel_n_q   <= 1'b1;
            mute_n_q  <= 1'b1;
            shift_q   <= GAIN_RESET;
            nbits_q   <= '0;
            sdo_q     <= 1'b0;
            target_q  <= GAIN_RESET;
            pend_q    <= 1'b0;
            gain_q    <= GAIN_RESET;
            st_q      <= SVSC_IDLE;
            tmr_q     <= '0;
            hw_mute_q <= 1'b0;
        end else begin
            sclk_q    <= sclk_d;
            sel_n_q   <= sel_n_d;
            mute_n_q  <= mute_n_d;
            shift_q   <= shift_d;
            nbits_q   <= nbits_d;
            sdo_q     <= sdo_d;
            target_q  <= target_d;
            pend_q    <= pend_d;
            gain_q    <= gain_d;
            st_q      <= st_d;
            tmr_q     <= tmr_d;
            hw_mute_q <= hw_mute_d;
        end
    end

    assign serial_chain_out_o        = sdo_q;
    assign serial_chain_out_oe_o     = ~sel_n_s;
    assign right_level_o             = gain_q[RIGHT_LSB +: CHAN_BITS];
    assign left_level_o              = gain_q[LEFT_LSB +: CHAN_BITS];
    assign right_soft_mute_o         = (right_level_o == SOFT_MUTE_CODE);
    assign left_soft_mute_o          = (left_level_o == SOFT_MUTE_CODE);
    assign left_analog_output_gnd_o  = hw_mute_q;
    assign right_analog_output_gnd_o = hw_mute_q;
    assign calibrating_o             = (st_q == SVSC_CAL);
    assign gain_word_o               = gain_q;
endmodule : svsc_top
